// ==== core/background_debug_regs.sv ====
/*
 Background debug unit pin duties and register block.
 Assumes a serial command decoder elsewhere delivers register read/write
 commands as a reg_cmd_t pulse, and that mode, security and debug-entry
 information arrive from core logic on the same clock. Pins pass two flops.
*/
// Functional notes
// - During reset the debug pin is sampled as the mode-select input.
// - After reset the debug pin serves only as the serial debug interface.
// - With tagging on, high tag pin low at external clock fall tags high half.
// - With tagging and low strobe on, low tag pin low tags low half.
// - Registers are reached only via debug register read and write commands.
// - Status 0xff01 and flags 0xff06 read/write; position 0xff07 read only.
// - Debug-active bit is set only by hardware on entering debug state.
// - Debug-active bit is cleared only by firmware table write on exit.
// - Clock select written only by hardware commands or firmware writes.
// - In special single-chip, unsecured or erased, debug enable reads one.
// - In special single-chip, unsecured flag reads one when secured and erased, else zero.
// - Status readable in every mode, writable subject to bit restrictions.
// - Flags register holds eight read/write condition-code bits.
// - Debug enable zero forbids active state; hardware commands still run.
// - Tag enable write disables serial and enables tagging 16 cycles later.
// - Clock select change is guaranteed after 150 cycles.
`timescale 1ns/1ps
`default_nettype none
module background_debug_regs (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic single_wire_debug_pin_i,
    input wire logic external_bus_clock_i,
    input wire debug_regs_pkg::tag_pair_t tag_pins_i,
    input wire logic low_strobe_en_i,
    input wire debug_regs_pkg::reg_cmd_t cmd_i,
    input wire logic enter_debug_i,
    input wire logic special_single_chip_i,
    input wire logic secured_i,
    input wire logic fully_erased_i,
    input wire logic shift_valid_set_i,
    input wire logic shift_valid_clr_i,
    input wire logic [7:0] position_i,
    output logic special_mode_o,
    output logic serial_enable_o,
    output logic debug_active_o,
    output logic clock_select_o,
    output logic clock_settled_o,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output debug_regs_pkg::tag_pair_t tag_hit_o
);
    import debug_regs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] single_wire_debug_pin_sync_q, single_wire_debug_pin_sync_d;
    logic [1:0] external_bus_clock_sync_q, external_bus_clock_sync_d;
    tag_pair_t tag_meta_q, tag_meta_d, tag_sync_q, tag_sync_d;
    logic external_bus_clock_prev_q, external_bus_clock_prev_d;

    always_comb begin
        single_wire_debug_pin_sync_d = {single_wire_debug_pin_sync_q[0], single_wire_debug_pin_i};
        external_bus_clock_sync_d = {external_bus_clock_sync_q[0], external_bus_clock_i};
        tag_meta_d = tag_pins_i;
        tag_sync_d = tag_meta_q;
        external_bus_clock_prev_d = external_bus_clock_sync_q[1];
    end

    always_ff @(posedge ref_clk_i) begin
        single_wire_debug_pin_sync_q <= single_wire_debug_pin_sync_d;
        external_bus_clock_sync_q <= external_bus_clock_sync_d;
        tag_meta_q <= tag_meta_d;
        tag_sync_q <= tag_sync_d;
        external_bus_clock_prev_q <= external_bus_clock_prev_d;
    end

    // ------------------------------------------------------------
    // Pin role and tagging sequencer
    // ------------------------------------------------------------
    link_state_t state_q, state_d;
    logic [TAG_CNT_W-1:0] tag_cnt_q, tag_cnt_d;
    logic special_q, special_d;
    tag_pair_t hit_q, hit_d;
    logic [7:0] status_q, status_d;
    logic external_bus_clock_fall;
    logic tag_wr;

    assign external_bus_clock_fall = external_bus_clock_prev_q & ~external_bus_clock_sync_q[1];

    always_comb begin
        state_d = state_q;
        tag_cnt_d = tag_cnt_q;
        special_d = special_q;
        hit_d = '0;
        unique case (state_q)
            ST_RESET: begin
                special_d = ~single_wire_debug_pin_sync_q[1];
                state_d = ST_SERIAL;
            end
            ST_SERIAL: begin
                if (tag_wr) begin
                    tag_cnt_d = '0;
                    state_d = ST_TAG_WAIT;
                end
            end
            ST_TAG_WAIT: begin
                tag_cnt_d = TAG_CNT_W'(tag_cnt_q + 1'b1);
                if (tag_cnt_q == TAG_CNT_W'(TAG_DELAY_CYCLES - 1)) begin
                    state_d = ST_TAGGING;
                end
                // Debug entry during the delay cancels tagging
                if (!status_q[BIT_TAG_ENABLE]) begin
                    state_d = ST_SERIAL;
                end
            end
            ST_TAGGING: begin
                if (external_bus_clock_fall) begin
                    hit_d.high_tag = ~tag_sync_q.high_tag;
                    hit_d.low_tag = ~tag_sync_q.low_tag & low_strobe_en_i;
                end
                if (!status_q[BIT_TAG_ENABLE]) begin
                    state_d = ST_SERIAL;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= ST_RESET;
            tag_cnt_q <= '0;
            hit_q <= '0;
        end else begin
            state_q <= state_d;
            tag_cnt_q <= tag_cnt_d;
            hit_q <= hit_d;
        end
        // Strap keeps following the pin while reset is held, then freezes
        special_q <= srst_i ? ~single_wire_debug_pin_sync_q[1] : special_d;
    end

    // ------------------------------------------------------------
    // Register block
    // ------------------------------------------------------------
    logic [7:0] flags_q, flags_d;
    logic [SW_CNT_W-1:0] sw_cnt_q, sw_cnt_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic cmd_ok;
    logic [7:0] status_view;

    // Serial commands still run during the tag delay, not once tagging owns the pin
    assign cmd_ok = (state_q == ST_SERIAL || state_q == ST_TAG_WAIT)
                    && (cmd_i.src_hw || cmd_i.src_fw);
    assign tag_wr = cmd_ok && cmd_i.wr && cmd_i.addr == ADDR_DEBUG_STATUS
                    && cmd_i.wdata[BIT_TAG_ENABLE];

    function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    always_comb begin
        status_view = status_q;
        status_view[0] = 1'b0;
        status_view[BIT_UNSECURED] = special_q && special_single_chip_i && secured_i && fully_erased_i;
        if (special_q && special_single_chip_i && (!secured_i || fully_erased_i)) begin
            status_view[BIT_DEBUG_ENABLE] = 1'b1;
        end
    end

    always_comb begin
        status_d = status_q;
        flags_d = flags_q;
        sw_cnt_d = (sw_cnt_q != '0) ? SW_CNT_W'(sw_cnt_q - 1'b1) : sw_cnt_q;
        rdata_d = 8'h00;
        rvalid_d = 1'b0;
        if (cmd_ok && cmd_i.wr) begin
            if (is_addr(cmd_i.addr, ADDR_DEBUG_STATUS)) begin
                status_d[BIT_DEBUG_ENABLE] = cmd_i.wdata[BIT_DEBUG_ENABLE];
                status_d[BIT_TAG_ENABLE] = cmd_i.wdata[BIT_TAG_ENABLE];
                status_d[BIT_TRACE] = cmd_i.wdata[BIT_TRACE];
                // Both permitted sources already gate cmd_ok
                if (cmd_i.wdata[BIT_CLOCK_SELECT] != status_q[BIT_CLOCK_SELECT]) begin
                    status_d[BIT_CLOCK_SELECT] = cmd_i.wdata[BIT_CLOCK_SELECT];
                    sw_cnt_d = SW_CNT_W'(DEBUG_CLOCK_SELECT_SETTLE_CYCLES);
                end
                if (cmd_i.src_fw && !cmd_i.wdata[BIT_DEBUG_ACTIVE]) begin
                    status_d[BIT_DEBUG_ACTIVE] = 1'b0;
                end
            end else if (is_addr(cmd_i.addr, ADDR_SAVED_FLAGS)) begin
                flags_d = cmd_i.wdata;
            end
            // Other addresses, position register included, ignore writes
        end
        if (cmd_ok && cmd_i.rd) begin
            rvalid_d = 1'b1;
            if (is_addr(cmd_i.addr, ADDR_DEBUG_STATUS)) begin
                rdata_d = status_view;
            end else if (is_addr(cmd_i.addr, ADDR_SAVED_FLAGS)) begin
                rdata_d = flags_q;
            end else if (is_addr(cmd_i.addr, ADDR_REG_POSITION)) begin
                rdata_d = position_i & POSITION_MASK;
            end
        end
        if (shift_valid_clr_i) begin
            status_d[BIT_SHIFT_VALID] = 1'b0;
        end
        if (shift_valid_set_i) begin
            status_d[BIT_SHIFT_VALID] = 1'b1;
        end
        // Entry wins over a same-cycle firmware clear; blocked when disabled
        if (enter_debug_i && status_view[BIT_DEBUG_ENABLE]) begin
            status_d[BIT_DEBUG_ACTIVE] = 1'b1;
            status_d[BIT_TAG_ENABLE] = 1'b0;
        end
        status_d[0] = 1'b0;
        status_d[BIT_UNSECURED] = 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_q <= STATUS_RESET;
            flags_q <= FLAGS_RESET;
            sw_cnt_q <= '0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            status_q <= status_d;
            flags_q <= flags_d;
            sw_cnt_q <= sw_cnt_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic serial_en_q, active_q, clksel_q, settled_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            serial_en_q <= 1'b0;
            active_q <= 1'b0;
            clksel_q <= 1'b0;
            settled_q <= 1'b1;
        end else begin
            serial_en_q <= (state_d == ST_SERIAL || state_d == ST_TAG_WAIT);
            active_q <= status_d[BIT_DEBUG_ACTIVE];
            clksel_q <= status_d[BIT_CLOCK_SELECT];
            settled_q <= (sw_cnt_d == '0);
        end
    end

    assign special_mode_o = special_q;
    assign serial_enable_o = serial_en_q;
    assign debug_active_o = active_q;
    assign clock_select_o = clksel_q;
    assign clock_settled_o = settled_q;
    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign tag_hit_o = hit_q;
endmodule
`default_nettype wire

// ==== core/debug_regs_pkg.sv ====
/*
 Package for the background debug register block: addresses, field positions,
 reset values, cycle counts and the carrier structs for commands and tag pins.
 Assumes an 8-bit debug data path and a 16-bit debug address space.
*/
package debug_regs_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RSVD_FIRST = 16'hff00;
    localparam logic [15:0] ADDR_RSVD_LAST = 16'hff0b;
    localparam logic [15:0] ADDR_DEBUG_STATUS = 16'hff01;
    localparam logic [15:0] ADDR_SAVED_FLAGS = 16'hff06;
    localparam logic [15:0] ADDR_REG_POSITION = 16'hff07;
    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int BIT_DEBUG_ENABLE = 7;
    localparam int BIT_DEBUG_ACTIVE = 6;
    localparam int BIT_TAG_ENABLE = 5;
    localparam int BIT_SHIFT_VALID = 4;
    localparam int BIT_TRACE = 3;
    localparam int BIT_CLOCK_SELECT = 2;
    localparam int BIT_UNSECURED = 1;
    // Position register keeps bits 6..3 only
    localparam logic [7:0] POSITION_MASK = 8'h78;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TAG_DELAY_CYCLES = 16;
    localparam int DEBUG_CLOCK_SELECT_SETTLE_CYCLES = 150;
    localparam int TAG_CNT_W = 5;
    localparam int SW_CNT_W = 8;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // src_hw: hardware command; src_fw: standard firmware table write
    typedef struct packed {
        logic rd;
        logic wr;
        logic src_hw;
        logic src_fw;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_cmd_t;
    typedef struct packed {
        logic high_tag;
        logic low_tag;
    } tag_pair_t;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_SERIAL,
        ST_TAG_WAIT,
        ST_TAGGING
    } link_state_t;
endpackage

// ==== tb/background_debug_regs_monitor.sv ====
/*
 Port checker for the debug register block.
 Assumes it is bound onto background_debug_regs and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module background_debug_regs_monitor
    import debug_regs_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire debug_regs_pkg::reg_cmd_t cmd_i,
    input wire logic enter_debug_i,
    input wire logic low_strobe_en_i,
    input wire logic [7:0] position_i,
    input wire logic serial_enable_o,
    input wire logic debug_active_o,
    input wire logic clock_select_o,
    input wire logic clock_settled_o,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire debug_regs_pkg::tag_pair_t tag_hit_o
);
    // ----------------------------------------
    // Taken commands
    // ----------------------------------------
    logic src_ok;
    logic take_rd;
    logic take_wr;
    logic tag_wr;
    assign src_ok = (cmd_i.src_hw || cmd_i.src_fw) && serial_enable_o;
    assign take_rd = cmd_i.rd && src_ok;
    assign take_wr = cmd_i.wr && src_ok;
    assign tag_wr = take_wr && cmd_i.addr == ADDR_DEBUG_STATUS && cmd_i.wdata[BIT_TAG_ENABLE];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    chk_read_answer: assert property (take_rd |=> rvalid_o)
        else $error("read command not answered");
    chk_no_stray: assert property (!take_rd |=> !rvalid_o)
        else $error("read data without a read");
    chk_position_mask: assert property (take_rd && cmd_i.addr == ADDR_REG_POSITION
        |=> rdata_o == ($past(position_i) & POSITION_MASK)) else $error("position read wrong");
    chk_active_cause: assert property ($rose(debug_active_o) |-> $past(enter_debug_i))
        else $error("active set without entry");
    chk_active_clear: assert property ($fell(debug_active_o) |-> $past(take_wr && cmd_i.src_fw))
        else $error("active cleared without firmware write");
    chk_clock_source: assert property ($changed(clock_select_o) |-> $past(take_wr))
        else $error("clock select changed without write");
    chk_settle_time: assert property ($changed(clock_select_o)
        |-> ##148 !clock_settled_o ##[1:4] clock_settled_o) else $error("clock settle time wrong");
    chk_tag_delay: assert property (tag_wr |-> ##16 serial_enable_o ##1 !serial_enable_o)
        else $error("tagging delay wrong");
    chk_tag_gate: assert property (tag_hit_o.low_tag |-> low_strobe_en_i && !serial_enable_o)
        else $error("low tag hit out of tagging");
    chk_tag_serial: assert property (tag_hit_o.high_tag |-> !serial_enable_o)
        else $error("high tag hit out of tagging");
    cover property (take_rd);
    cover property ($rose(debug_active_o));
    cover property (tag_hit_o.high_tag);
    cover property (tag_hit_o.low_tag);
endmodule
bind background_debug_regs background_debug_regs_monitor u_background_debug_regs_monitor (.*);
`default_nettype wire

// ==== tb/debug_host_model.sv ====
/*
 Host side model: mode strap on the debug pin, free running external
 bus clock and active-low tag pins. Assumes pulled-up pins idle high.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
    import debug_regs_pkg::*;
(
    output logic debug_pin_o,
    output logic bus_clk_o,
    output tag_pair_t tags_o
);
    initial begin
        bus_clk_o = 1'b0;
        tags_o = 2'b11;
    end
    // Half period a multiple of four never lands on a core clock rising edge
    always #232 bus_clk_o = ~bus_clk_o;
    task automatic strap(input logic v);
        debug_pin_o = v;
    endtask
    // Tags held across the whole low phase so the synchroniser cannot miss them
    task automatic tag_fetch(input logic hi, input logic lo);
        @(posedge bus_clk_o);
        tags_o = {~hi, ~lo};
        @(negedge bus_clk_o);
        @(posedge bus_clk_o);
        tags_o = 2'b11;
    endtask
endmodule
`default_nettype wire

// ==== tb/background_debug_regs_bench.sv ====
/*
 Self-checking bench for the debug register block.
 Assumes the host model drives the pins and the bench issues commands.
*/
`timescale 1ns/1ps
`default_nettype none
module background_debug_regs_bench;
    import debug_regs_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic pin, bclk, special, ser_en, active, csel, settled, rvalid;
    logic lse = 1'b0, enter = 1'b0, secured = 1'b0, erased = 1'b0;
    logic ssc = 1'b1, sv_set = 1'b0, sv_clr = 1'b0, seen_clr = 1'b0;
    logic [7:0] position = 8'h00, rdata;
    tag_pair_t tags, hit, seen = 2'b00;
    reg_cmd_t cmd = '0;
    int n_errors = 0, n_compared = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) seen <= seen_clr ? 2'b00 : (seen | hit);
    debug_host_model u_debug_host_model (.debug_pin_o(pin), .bus_clk_o(bclk), .tags_o(tags));
    background_debug_regs u_background_debug_regs (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .single_wire_debug_pin_i(pin), .external_bus_clock_i(bclk), .tag_pins_i(tags),
        .low_strobe_en_i(lse), .cmd_i(cmd), .enter_debug_i(enter), .special_single_chip_i(ssc),
        .secured_i(secured), .fully_erased_i(erased), .shift_valid_set_i(sv_set),
        .shift_valid_clr_i(sv_clr), .position_i(position), .special_mode_o(special),
        .serial_enable_o(ser_en), .debug_active_o(active), .clock_select_o(csel),
        .clock_settled_o(settled), .rdata_o(rdata), .rvalid_o(rvalid), .tag_hit_o(hit));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] src, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i) cmd <= {2'b01, src, a, d};
        @(posedge ref_clk_i) cmd <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic v, input logic [7:0] exp);
        @(posedge ref_clk_i) cmd <= {4'b1010, a, 8'h00};
        @(posedge ref_clk_i) cmd <= '0;
        #1 check({7'h0, rvalid}, {7'h0, v});
        if (v) check(rdata, exp);
    endtask
    task automatic final_report;
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1_000_000 n_errors++;
        final_report;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        u_debug_host_model.strap(1'b0);
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1 u_debug_host_model.strap(1'b1);
        repeat (3) @(posedge ref_clk_i);
        #1 check({7'h0, special}, 8'h01);
        check({7'h0, ser_en}, 8'h01);
        $display("test strap done");
        wr(2'b10, ADDR_SAVED_FLAGS, 8'ha5);
        rd(ADDR_SAVED_FLAGS, 1'b1, 8'ha5);
        wr(2'b01, ADDR_SAVED_FLAGS, 8'h5a);
        wr(2'b00, ADDR_SAVED_FLAGS, 8'hff);
        rd(ADDR_SAVED_FLAGS, 1'b1, 8'h5a);
        @(posedge ref_clk_i) position <= 8'hff;
        wr(2'b10, ADDR_REG_POSITION, 8'h00);
        rd(ADDR_REG_POSITION, 1'b1, POSITION_MASK);
        for (int a = 0; a < 12; a++) begin
            if (!(a inside {1, 6, 7})) begin
                wr(2'b10, ADDR_RSVD_FIRST + 16'(a), 8'hff);
                rd(ADDR_RSVD_FIRST + 16'(a), 1'b1, 8'h00);
            end
        end
        rd(16'h1234, 1'b1, 8'h00);
        rd(ADDR_SAVED_FLAGS, 1'b1, 8'h5a);
        $display("test map done");
        @(posedge ref_clk_i) ssc <= 1'b0;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h00);
        @(posedge ref_clk_i) ssc <= 1'b1;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h80);
        @(posedge ref_clk_i) {secured, erased} <= 2'b11;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h82);
        @(posedge ref_clk_i) erased <= 1'b0;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h00);
        @(posedge ref_clk_i) secured <= 1'b0;
        wr(2'b10, ADDR_DEBUG_STATUS, 8'h4c);
        #1 check({7'h0, settled}, 8'h00);
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h8c);
        repeat (152) @(posedge ref_clk_i);
        #1 check({7'h0, settled}, 8'h01);
        wr(2'b01, ADDR_DEBUG_STATUS, 8'h80);
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h80);
        @(posedge ref_clk_i) {sv_set, sv_clr} <= 2'b11;
        @(posedge ref_clk_i) {sv_set, sv_clr} <= 2'b00;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h90);
        @(posedge ref_clk_i) sv_clr <= 1'b1;
        @(posedge ref_clk_i) sv_clr <= 1'b0;
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h80);
        repeat (152) @(posedge ref_clk_i);
        $display("test status done");
        wr(2'b10, ADDR_DEBUG_STATUS, 8'h00);
        @(posedge ref_clk_i) {ssc, enter} <= 2'b01;
        @(posedge ref_clk_i) {ssc, enter} <= 2'b10;
        #1 check({7'h0, active}, 8'h00);
        @(posedge ref_clk_i) enter <= 1'b1;
        @(posedge ref_clk_i) enter <= 1'b0;
        #1 check({7'h0, active}, 8'h01);
        wr(2'b10, ADDR_DEBUG_STATUS, 8'h80);
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'hc0);
        wr(2'b01, ADDR_DEBUG_STATUS, 8'h80);
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h80);
        $display("test entry done");
        @(posedge ref_clk_i) lse <= 1'b1;
        wr(2'b10, ADDR_DEBUG_STATUS, 8'ha0);
        rd(ADDR_SAVED_FLAGS, 1'b1, 8'h5a);
        repeat (12) @(posedge ref_clk_i);
        #1 check({7'h0, ser_en}, 8'h01);
        repeat (4) @(posedge ref_clk_i);
        #1 check({7'h0, ser_en}, 8'h00);
        rd(ADDR_SAVED_FLAGS, 1'b0, 8'h00);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_i) {lse, seen_clr} <= {k != 2, 1'b1};
            @(posedge ref_clk_i) seen_clr <= 1'b0;
            u_debug_host_model.tag_fetch(k != 1, k != 0);
            repeat (4) @(posedge ref_clk_i);
            #1 check({6'h0, seen}, (k == 1) ? 8'h01 : 8'h02);
        end
        @(posedge ref_clk_i) enter <= 1'b1;
        @(posedge ref_clk_i) enter <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        rd(ADDR_SAVED_FLAGS, 1'b1, 8'h5a);
        $display("test tagging done");
        @(posedge ref_clk_i) srst_i <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 check({7'h0, special}, 8'h00);
        check({7'h0, active}, 8'h00);
        rd(ADDR_DEBUG_STATUS, 1'b1, 8'h00);
        $display("test second reset done");
        final_report;
    end
endmodule
`default_nettype wire
